// File: rtl/booster_pwm_gen.sv
// Internal 50% duty booster clock generator selected by frequency code
`timescale 1ns/1ns
module booster_pwm_gen
   import fso_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic enable,
   input wire logic [2:0] freq_code,
   output logic pwm
);
   logic [7:0] cnt_q;
   logic [7:0] half_cnt;

   // half period picked by frequency code
   assign half_cnt = 8'(half_period(freq_code));

   // Equal high and low phases give a 50% duty cycle
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= 8'h00;
         pwm <= 1'b0;
      end else if (!enable) begin
         cnt_q <= 8'h00;
         pwm <= 1'b0;
      end else if (cnt_q >= half_cnt - 8'h01) begin
         cnt_q <= 8'h00;
         pwm <= ~pwm;
      end else begin
         cnt_q <= cnt_q + 8'h01;
      end
   end
endmodule : booster_pwm_gen

// File: rtl/fso_mode_ctrl.sv
// Fail-safe and stand-alone mode controller with Avalon-MM register slave
//
// Summary of operation
// - No entry unless customer OTP is locked.
// - Pin select 0: pin edges enter and exit.
// - Pin select 1: fail-safe never entered.
// - Pin select rising to 1 exits fail-safe.
// - Independent phase control off in fail-safe.
// - Mode code loaded from locked OTP at power-up.
// - Entry sets status flag, read clears it.
// - Activation reloads control fields from OTP.
// - Fail-safe uses internal 50% duty clock.
// - Frequency code selects internal booster frequency.
// - Auto-recovery forced high in fail-safe.
// - Auto-recovery from OTP only in mode 1.
// - Pin-entered fail-safe forces both phases on.
// - On exit phases return to loaded enables.
// - Modes 6,7 at startup; 2-5 and armed 7 by pin.
// - POR clears or OTP-loads registers by mode.
// - Modes 2,4,6 block writes and clears in fail-safe.
// - Writing mode 0 or 1 exits fail-safe.
`timescale 1ns/1ns
module fso_mode_ctrl
   import fso_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic otp_ready,
   input wire logic otp_locked,
   input wire logic [2:0] otp_mode_code,
   input wire logic [31:0] otp_ctrl_image,
   input wire logic spi_frame_invalid,
   input wire logic failsafe_enable_pin,
   output logic irq,
   output logic failsafe_active,
   output logic internal_clk_sel,
   output logic booster_pwm,
   output logic [1:0] phase_enable_bits,
   output logic thermal_auto_recovery_en,
   output logic phase_independent_ctrl,
   output logic [31:0] ctrl_word
);
   fso_state_t state_q;
   logic [2:0] mode_q;
   logic [31:0] ctrl_q;
   logic [STATUS_W-1:0] status_q;
   logic [STATUS_W-1:0] mask_q;
   logic [STATUS_W-1:0] status_set;
   logic [STATUS_W-1:0] status_clr;
   logic by_pin_q;
   logic armed7_q;
   logic wait_q;
   logic [31:0] rdata_q;
   logic acc_rd;
   logic acc_wr;
   logic locked;
   logic wr_ok;
   logic wr_mode;
   logic wr_ctrl;
   logic [31:0] ctrl_merged;
   logic startup_entry;
   logic pin_entry;
   logic exit_pin;
   logic exit_sw;
   logic exit_any;
   logic in_fs;

   pin_edge_if pin_ev ();

   // Mode permits entry directly after startup
   function automatic logic mode_startup(input logic [2:0] m);
      logic r;
      r = 1'b0;
      case (m)
         3'h6, 3'h7: r = 1'b1;
         default: r = 1'b0;
      endcase
      return r;
   endfunction : mode_startup

   // Mode permits entry on a falling pin edge
   function automatic logic mode_pin(input logic [2:0] m, input logic armed);
      logic r;
      r = 1'b0;
      case (m)
         3'h2, 3'h3, 3'h4, 3'h5: r = 1'b1;
         3'h7: r = armed;
         default: r = 1'b0;
      endcase
      return r;
   endfunction : mode_pin

   // Mode loads control registers from OTP at power-up
   function automatic logic mode_por_otp(input logic [2:0] m);
      logic r;
      r = 1'b0;
      case (m)
         3'h1, 3'h4, 3'h5, 3'h6, 3'h7: r = 1'b1;
         default: r = 1'b0;
      endcase
      return r;
   endfunction : mode_por_otp

   // Mode forbids register updates while in fail-safe
   function automatic logic mode_locks(input logic [2:0] m);
      logic r;
      r = 1'b0;
      case (m)
         3'h2, 3'h4, 3'h6: r = 1'b1;
         default: r = 1'b0;
      endcase
      return r;
   endfunction : mode_locks

   // Byte-enable merge of a write into an old word
   function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction : be_merge

   pin_edge_sync u_pin_sync (
      .clk(clk),
      .rst_b(rst_b),
      .pin_raw(failsafe_enable_pin),
      .ev(pin_ev)
   );

   booster_pwm_gen u_pwm (
      .clk(clk),
      .rst_b(rst_b),
      .enable(in_fs),
      .freq_code(ctrl_q[CTRL_FREQ_LSB +: 3]),
      .pwm(booster_pwm)
   );

   // Bus access accepted on the edge where waitrequest is low
   assign acc_rd = avs_read && !wait_q;
   assign acc_wr = avs_write && !wait_q;
   assign in_fs = (state_q == S_FAILSAFE);

   assign locked = in_fs && mode_locks(mode_q);
   assign wr_ok = acc_wr && !locked;
   assign wr_mode = wr_ok && (avs_address == OFS_MODE) && avs_byteenable[0];
   assign wr_ctrl = wr_ok && (avs_address == OFS_CTRL);
   assign ctrl_merged = be_merge(ctrl_q, avs_writedata, avs_byteenable);

   // startup entry in modes 6 and 7
   // refused when loaded pin select is 1
   assign startup_entry = (state_q == S_INIT) && otp_ready && otp_locked
                          && mode_startup(otp_mode_code) && !otp_ctrl_image[CTRL_PSEL];

   assign pin_entry = (state_q == S_NORMAL) && otp_locked && !ctrl_q[CTRL_PSEL]
                      && mode_pin(mode_q, armed7_q) && pin_ev.fall;

   // pin rising edge exits pin-entered fail-safe
   assign exit_pin = in_fs && by_pin_q && !ctrl_q[CTRL_PSEL] && pin_ev.rise;

   // mode written to 0 or 1 exits
   // pin select set to 1 exits at once
   assign exit_sw = in_fs && ((wr_mode && avs_writedata[2:0] <= 3'h1)
                    || (wr_ctrl && ctrl_merged[CTRL_PSEL]) || ctrl_q[CTRL_PSEL]);
   assign exit_any = exit_pin || exit_sw;

   // Mode controller state
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= S_INIT;
         by_pin_q <= 1'b0;
      end else begin
         case (state_q)
            S_INIT: begin
               if (startup_entry) begin
                  state_q <= S_FAILSAFE;
                  by_pin_q <= 1'b0;
               end else if (otp_ready) begin
                  state_q <= S_NORMAL;
               end
            end
            S_NORMAL: begin
               if (pin_entry) begin
                  state_q <= S_FAILSAFE;
                  by_pin_q <= 1'b1;
               end
            end
            S_FAILSAFE: begin
               if (exit_any) begin
                  state_q <= S_NORMAL;
                  by_pin_q <= 1'b0;
               end
            end
            default: begin
               state_q <= S_INIT;
            end
         endcase
      end
   end

   // Mode code register and mode 7 pin-entry arming
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_q <= MODE_RESET;
         armed7_q <= 1'b0;
      end else if (state_q == S_INIT) begin
         // mode taken from OTP only at power-up
         if (otp_ready && otp_locked) begin
            mode_q <= otp_mode_code;
         end
      end else if (wr_mode) begin
         mode_q <= avs_writedata[2:0];
         // mode 7 pin entry after proper update
         armed7_q <= (avs_writedata[2:0] == 3'h7);
      end
   end

   // Control word: power-up load, activation reload, software write
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_q <= CTRL_RESET;
      end else if (state_q == S_INIT) begin
         if (otp_ready) begin
            // OTP load or clear by mode
            if (otp_locked && mode_por_otp(otp_mode_code)) begin
               ctrl_q <= otp_ctrl_image;
               // auto-recovery only from OTP in mode 1
               ctrl_q[CTRL_AUTOREC] <= (otp_mode_code == 3'h1) && otp_ctrl_image[CTRL_AUTOREC];
            end else begin
               ctrl_q <= CTRL_RESET;
            end
         end
      end else if (pin_entry) begin
         ctrl_q <= otp_ctrl_image;
         // auto-recovery not taken from OTP here
         ctrl_q[CTRL_AUTOREC] <= ctrl_q[CTRL_AUTOREC];
      end else if (wr_ctrl) begin
         ctrl_q <= ctrl_merged;
      end
   end

   // Status events, each set wins over a clear
   always_comb begin
      status_set = '0;
      status_set[ST_ENTRY] = startup_entry || pin_entry;
      status_set[ST_FRAME_ERR] = spi_frame_invalid || (acc_wr && locked);
      status_set[ST_EXIT] = in_fs && exit_any;
      status_set[ST_REFUSED] = acc_wr && locked;
   end

   // read of status clears the bits returned
   assign status_clr = (acc_rd && (avs_address == OFS_STATUS) && !locked)
                       ? rdata_q[STATUS_W-1:0] : '0;

   // Sticky status register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         status_q <= '0;
      end else begin
         status_q <= (status_q & ~status_clr) | status_set;
      end
   end

   // Interrupt mask register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mask_q <= MASK_RESET;
      end else if (wr_ok && (avs_address == OFS_MASK) && avs_byteenable[0]) begin
         mask_q <= avs_writedata[STATUS_W-1:0];
      end
   end

   // One wait state: waitrequest drops for one cycle per request
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wait_q <= 1'b1;
      end else begin
         wait_q <= !((avs_read || avs_write) && wait_q);
      end
   end

   // Read data captured while waitrequest is high, held through the answer
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_q <= 32'h0000_0000;
      end else if (avs_read && wait_q) begin
         if (avs_address == OFS_MODE) begin
            rdata_q <= {29'h0000_0000, mode_q};
         end else if (avs_address == OFS_CTRL) begin
            rdata_q <= ctrl_q;
         end else if (avs_address == OFS_STATUS) begin
            rdata_q <= {28'h000_0000, status_q};
         end else if (avs_address == OFS_MASK) begin
            rdata_q <= {28'h000_0000, mask_q};
         end else if (avs_address == OFS_STATE) begin
            rdata_q <= 32'h0000_0000;
            rdata_q[SR_FAILSAFE] <= in_fs;
            rdata_q[SR_BY_PIN] <= by_pin_q;
            rdata_q[SR_PIN_LEVEL] <= pin_ev.level;
            rdata_q[SR_ARMED7] <= armed7_q;
            rdata_q[SR_CLK_SEL] <= in_fs;
         end else begin
            rdata_q <= 32'h0000_0000;
         end
      end
   end

   assign avs_readdata = rdata_q;
   assign avs_waitrequest = wait_q;

   // Registered block outputs
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq <= 1'b0;
         failsafe_active <= 1'b0;
         internal_clk_sel <= 1'b0;
         phase_enable_bits <= 2'h0;
         thermal_auto_recovery_en <= 1'b0;
         phase_independent_ctrl <= 1'b0;
         ctrl_word <= CTRL_RESET;
      end else begin
         irq <= |(status_q & mask_q);
         failsafe_active <= in_fs;
         // internal source in fail-safe and stand-alone
         internal_clk_sel <= in_fs;
         // after exit the loaded enables apply
         phase_enable_bits <= (in_fs && by_pin_q) ? 2'h3 : ctrl_q[CTRL_PHASE_LSB +: 2];
         thermal_auto_recovery_en <= in_fs || ctrl_q[CTRL_AUTOREC];
         phase_independent_ctrl <= ctrl_q[CTRL_PSEL] && !in_fs;
         ctrl_word <= ctrl_q;
      end
   end
endmodule : fso_mode_ctrl

// File: rtl/fso_pkg.sv
// Package with register map, field layout and timing constants of the fail-safe mode controller
package fso_pkg;
   // Core clock rate in Hz
   localparam int unsigned CLK_HZ = 10_000_000;
   // Internal booster frequencies in tenths of kHz, indexed by frequency code
   localparam int unsigned FREQ_DHZ [8] = '{
      2000, 2941, 4167, 5000, 6250, 7143, 8330, 10000
   };
   // Register byte offsets
   localparam logic [4:0] OFS_MODE = 5'h00;
   localparam logic [4:0] OFS_CTRL = 5'h04;
   localparam logic [4:0] OFS_STATUS = 5'h08;
   localparam logic [4:0] OFS_MASK = 5'h0C;
   localparam logic [4:0] OFS_STATE = 5'h10;
   // Control word layout
   localparam int CTRL_PSEL = 0;
   localparam int CTRL_AUTOREC = 1;
   localparam int CTRL_PHASE_LSB = 2;
   localparam int CTRL_FREQ_LSB = 4;
   localparam int CTRL_VDD = 7;
   // Status bits
   localparam int ST_ENTRY = 0;
   localparam int ST_FRAME_ERR = 1;
   localparam int ST_EXIT = 2;
   localparam int ST_REFUSED = 3;
   localparam int STATUS_W = 4;
   // State register bits
   localparam int SR_FAILSAFE = 0;
   localparam int SR_BY_PIN = 1;
   localparam int SR_PIN_LEVEL = 2;
   localparam int SR_ARMED7 = 3;
   localparam int SR_CLK_SEL = 4;
   // Reset values
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [2:0] MODE_RESET = 3'h0;
   localparam logic [STATUS_W-1:0] MASK_RESET = 4'h0;
   // Controller states
   typedef enum logic [1:0] {
      S_INIT,
      S_NORMAL,
      S_FAILSAFE
   } fso_state_t;
   // Half period in core cycles for a frequency code: full period rounded to nearest, then halved with truncation
   function automatic int unsigned half_period(input logic [2:0] code);
      int unsigned full;
      full = (CLK_HZ / 100 + FREQ_DHZ[code] / 2) / FREQ_DHZ[code];
      return full / 2;
   endfunction : half_period
endpackage : fso_pkg

// File: rtl/pin_edge_if.sv
// Interface carrying the synchronised fail-safe pin level and its edges
`timescale 1ns/1ns
interface pin_edge_if;
   logic level;
   logic fall;
   logic rise;
   modport src (output level, output fall, output rise);
   modport dst (input level, input fall, input rise);
endinterface : pin_edge_if

// File: rtl/pin_edge_sync.sv
// Two-stage synchroniser and edge detector for the fail-safe pin
`timescale 1ns/1ns
module pin_edge_sync (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic pin_raw,
   pin_edge_if.src ev
);
   logic meta_q;
   logic sync_q;
   logic prev_q;

   // Idle level is high so reset produces no false edge
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_q <= 1'b1;
         sync_q <= 1'b1;
         prev_q <= 1'b1;
      end else begin
         meta_q <= pin_raw;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // Edges come from two successive synchronised samples
   assign ev.level = sync_q;
   assign ev.fall = prev_q & ~sync_q;
   assign ev.rise = ~prev_q & sync_q;
endmodule : pin_edge_sync

// File: tb/fso_far_model.sv
// Far-side model: customer OTP contents, fail-safe pin and framer pulses
`timescale 1ns/1ns
module fso_far_model (
   input wire logic clk,
   input wire logic rst_b,
   output logic otp_ready,
   output logic otp_locked,
   output logic [2:0] otp_mode_code,
   output logic [31:0] otp_ctrl_image,
   output logic spi_frame_invalid,
   output logic failsafe_enable_pin
);
   logic [1:0] refresh_q;
   // OTP refresh completes three cycles after reset release
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         refresh_q <= 2'h0;
         otp_ready <= 1'b0;
      end else begin
         if (refresh_q != 2'h2) begin
            refresh_q <= refresh_q + 2'h1;
         end
         otp_ready <= (refresh_q == 2'h2);
      end
   end
   // OTP blank, pin released high
   initial begin
      otp_locked = 1'b0;
      otp_mode_code = 3'h0;
      otp_ctrl_image = 32'h0;
      spi_frame_invalid = 1'b0;
      failsafe_enable_pin = 1'b1;
   end
   // New OTP contents, taken by the refresh after the next reset
   task automatic load(input logic l, input logic [2:0] m, input logic [31:0] im);
      otp_locked <= l;
      otp_mode_code <= m;
      otp_ctrl_image <= im;
      failsafe_enable_pin <= 1'b1;
   endtask : load
   task automatic pin(input logic v);
      failsafe_enable_pin <= v;
   endtask : pin
   // One-cycle invalid frame indication
   task automatic frame_err();
      @(posedge clk);
      spi_frame_invalid <= 1'b1;
      @(posedge clk);
      spi_frame_invalid <= 1'b0;
   endtask : frame_err
endmodule : fso_far_model

// File: tb/fso_mode_ctrl_checker.sv
// Port-level checker of the fail-safe mode controller
`timescale 1ns/1ns
module fso_mode_ctrl_checker
   import fso_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic otp_locked,
   input wire logic irq,
   input wire logic failsafe_active,
   input wire logic internal_clk_sel,
   input wire logic booster_pwm,
   input wire logic thermal_auto_recovery_en,
   input wire logic phase_independent_ctrl,
   input wire logic [31:0] ctrl_word
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Bus answer timing
   a_bus_answer_due: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("waitrequest not low one cycle after request");
   a_bus_answer_short: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   // Mode-dependent outputs
   a_clk_sel_follows: assert property (internal_clk_sel == failsafe_active)
      else $error("clock select differs from fail-safe state");
   a_autorec_held: assert property (failsafe_active && $past(failsafe_active) |-> thermal_auto_recovery_en)
      else $error("auto-recovery low in fail-safe");
   a_indep_ctrl_off: assert property (failsafe_active && $past(failsafe_active) |-> !phase_independent_ctrl)
      else $error("independent phase control on in fail-safe");
   a_pwm_quiet: assert property (!failsafe_active && !$past(failsafe_active) && !$past(failsafe_active, 2)
      |-> !booster_pwm)
      else $error("internal clock running outside fail-safe");
   // Entry and exit conditions
   a_entry_locked: assert property ($rose(failsafe_active) |-> otp_locked)
      else $error("fail-safe entered without OTP lock");
   a_entry_select: assert property ($rose(failsafe_active) |-> !$past(ctrl_word[CTRL_PSEL]))
      else $error("fail-safe entered with pin select set");
   a_select_exit: assert property (failsafe_active && ctrl_word[CTRL_PSEL] |-> ##[1:2] !failsafe_active)
      else $error("fail-safe kept after pin select set");
   c_entry: cover property ($rose(failsafe_active));
   c_exit: cover property ($fell(failsafe_active));
   c_irq: cover property ($rose(irq));
endmodule : fso_mode_ctrl_checker

bind fso_mode_ctrl fso_mode_ctrl_checker chk (.clk(clk), .rst_b(rst_b), .avs_read(avs_read),
   .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .otp_locked(otp_locked), .irq(irq),
   .failsafe_active(failsafe_active), .internal_clk_sel(internal_clk_sel), .booster_pwm(booster_pwm),
   .thermal_auto_recovery_en(thermal_auto_recovery_en), .phase_independent_ctrl(phase_independent_ctrl),
   .ctrl_word(ctrl_word));

// File: tb/fso_mode_ctrl_tb.sv
// Self-checking testbench of the fail-safe mode controller
`timescale 1ns/1ns
module fso_mode_ctrl_tb;
   import fso_pkg::*;
   logic clk, rst_b, rd, wr, wreq, irq, fa, csel, pwm, ind, ar, rdy, lock, ferr, pin;
   logic [4:0] adr;
   logic [31:0] wd, rdat, cw, img;
   logic [3:0] be;
   logic [2:0] omode;
   logic [1:0] ph;
   int fails, checks_done;
   // Half periods in cycles for codes 0..7 at 10 MHz
   int hp [8] = '{25, 17, 12, 10, 8, 7, 6, 5};
   fso_far_model far (.clk(clk), .rst_b(rst_b), .otp_ready(rdy), .otp_locked(lock), .otp_mode_code(omode),
      .otp_ctrl_image(img), .spi_frame_invalid(ferr), .failsafe_enable_pin(pin));
   fso_mode_ctrl uut (.clk(clk), .rst_b(rst_b), .avs_address(adr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wreq),
      .otp_ready(rdy), .otp_locked(lock), .otp_mode_code(omode), .otp_ctrl_image(img),
      .spi_frame_invalid(ferr), .failsafe_enable_pin(pin), .irq(irq), .failsafe_active(fa),
      .internal_clk_sel(csel), .booster_pwm(pwm), .phase_enable_bits(ph),
      .thermal_auto_recovery_en(ar), .phase_independent_ctrl(ind), .ctrl_word(cw));
   // Clock generator
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask : chk
   // Avalon-MM transfer, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clk);
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (wreq === 1'b0) break;
      end
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      if (n == 50) begin
         fails++;
         report_and_stop();
      end
   endtask : bus
   task automatic wrr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wrr
   task automatic rdc(input string what, input logic [4:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(what, e, q);
   endtask : rdc
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask : cyc
   task automatic wait_fa(input logic e, input string what);
      int n;
      for (n = 0; n < 20 && fa !== e; n++) @(posedge clk);
      chk(what, e, fa);
      if (fa !== e) report_and_stop();
   endtask : wait_fa
   // Measures the third level run of the internal clock
   task automatic half(input int e);
      int n, k;
      logic p;
      for (k = 0; k < 3; k++) begin
         p = pwm;
         for (n = 0; n < 60 && pwm === p; n++) @(posedge clk);
      end
      chk("pwm half period", e, n);
   endtask : half
   task automatic boot(input logic l, input logic [2:0] m, input logic [31:0] im);
      far.load(l, m, im);
      rst_b <= 1'b0;
      cyc(12);
      rst_b <= 1'b1;
      cyc(6);
   endtask : boot
   // Main sequence
   initial begin
      int i;
      logic [31:0] e;
      fails = 0;
      checks_done = 0;
      rst_b = 1'b0;
      rd = 1'b0;
      wr = 1'b0;
      adr = 5'h00;
      wd = 32'h0;
      be = 4'hF;
      boot(1'b0, 3'h6, 32'h0000_00F0);
      cyc(8);
      chk("active unlocked", 0, fa);
      rdc("mode unlocked", OFS_MODE, 32'h0);
      // Mode 2: pin entry, locked registers, exit by pin
      boot(1'b1, 3'h2, 32'h1234_5634);
      rdc("mode", OFS_MODE, 32'h2);
      rdc("ctrl cleared", OFS_CTRL, 32'h0);
      rdc("unmapped", 5'h14, 32'h0);
      wrr(OFS_MASK, 32'h1);
      far.pin(1'b0);
      wait_fa(1'b1, "pin entry");
      cyc(2);
      chk("reload", 32'h1234_5634, cw);
      chk("phases forced", 2'h3, ph);
      chk("irq entry", 1'b1, irq);
      rdc("status entry", OFS_STATUS, 32'h1);
      rdc("state pin entry", OFS_STATE, 32'h13);
      chk("clock select", 1'b1, csel);
      chk("indep ctrl off", 1'b0, ind);
      wrr(OFS_CTRL, 32'h0);
      rdc("ctrl kept", OFS_CTRL, 32'h1234_5634);
      far.frame_err();
      rdc("status locked", OFS_STATUS, 32'hB);
      half(hp[3]);
      far.pin(1'b1);
      wait_fa(1'b0, "pin exit");
      cyc(3);
      chk("phases exit", 2'h1, ph);
      rdc("status exit", OFS_STATUS, 32'hF);
      rdc("status clear", OFS_STATUS, 32'h0);
      cyc(2);
      chk("irq clear", 1'b0, irq);
      // Mode 3: frequency codes, select exit, software exit
      boot(1'b1, 3'h3, 32'h0000_0080);
      // Byte lanes: CTRL takes lane 1 only, MODE needs lane 0
      be <= 4'h2;
      wrr(OFS_CTRL, 32'hFFFF_FFFF);
      wrr(OFS_MODE, 32'h0);
      be <= 4'hF;
      rdc("ctrl lane", OFS_CTRL, 32'h0000_FF00);
      rdc("mode lane", OFS_MODE, 32'h3);
      far.pin(1'b0);
      wait_fa(1'b1, "entry mode 3");
      for (i = 0; i < 8; i++) begin
         wrr(OFS_CTRL, {24'h0, 1'b1, i[2:0], 4'h0});
         half(hp[i]);
      end
      wrr(OFS_CTRL, 32'h1);
      wait_fa(1'b0, "select exit");
      far.pin(1'b1);
      cyc(8);
      chk("indep ctrl on", 1'b1, ind);
      far.pin(1'b0);
      cyc(12);
      chk("select blocks entry", 0, fa);
      wrr(OFS_CTRL, 32'h0);
      far.pin(1'b1);
      cyc(8);
      far.pin(1'b0);
      wait_fa(1'b1, "entry again");
      wrr(OFS_MODE, 32'h0);
      wait_fa(1'b0, "mode write exit");
      // Power-up behaviour of every mode code
      for (i = 0; i < 8; i++) begin
         boot(1'b1, i[2:0], 32'h0000_00AA);
         if (i >= 6) wait_fa(1'b1, "startup entry");
         cyc(8);
         chk("startup state", i >= 6, fa);
         e = (i == 0 || i == 2 || i == 3) ? 32'h0 : ((i == 1) ? 32'hAA : 32'hA8);
         rdc("ctrl power-up", OFS_CTRL, e);
         chk("auto-recovery", i == 1 || i >= 6, ar);
         if (i == 7) chk("standalone phases", 2'h2, ph);
         if (i == 7) half(hp[2]);
      end
      // Mode 7: pin entry only after software writes the mode
      wrr(OFS_CTRL, 32'h1);
      wait_fa(1'b0, "mode 7 select exit");
      wrr(OFS_CTRL, 32'h0);
      far.pin(1'b0);
      cyc(12);
      chk("mode 7 unarmed", 0, fa);
      far.pin(1'b1);
      cyc(4);
      wrr(OFS_MODE, 32'h7);
      far.pin(1'b0);
      wait_fa(1'b1, "mode 7 pin entry");
      cyc(2);
      rdc("state mode 7", OFS_STATE, 32'h1B);
      chk("mode 7 phases", 2'h3, ph);
      report_and_stop();
   end
endmodule : fso_mode_ctrl_tb
